//--- design/dcf_consts.svh
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH

// storage organisation
`define DCF_WIDTH 18
`define DCF_DEPTH 8192
// default almost-flag offsets
`define DCF_OFF_PARALLEL 127
`define DCF_OFF_SERIAL 1023
// read clock transitions before a fall-through first word
`define DCF_FT_LATENCY 3
`endif

//--- design/dcf_pkg.sv
`include "dcf_consts.svh"
package dcf_pkg;
    // output timing mode, one-hot
    typedef enum logic [1:0] {
        DCF_HELD = 2'b01,
        DCF_FALL = 2'b10
    } dcf_mode_t;

    // sampled pin bundle, one synchroniser vector
    typedef struct packed {
        logic wclk;
        logic rclk;
        logic wen_n;
        logic ren_n;
        logic sen_n;
        logic ld_n;
        logic mrs_n;
        logic prs_n;
        logic rt_n;
        logic oe_n;
        logic fts;
        logic [`DCF_WIDTH-1:0] din;
    } dcf_pins_t;
endpackage

//--- design/dcf_sync.sv
`timescale 1ns/10ps
// ==========================================
// two-flop synchroniser for pin inputs
module dcf_sync #(
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } dcf_sync_t;

    dcf_sync_t s;
    dcf_sync_t next_s;

    // first stage feeds only the second stage
    always_comb begin
        next_s = s;
        next_s.stage1 = async_in;
        next_s.stage2 = s.stage1;
    end

    // state register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sync_out = s.stage2;
endmodule

//--- design/dcf_ram.sv
`timescale 1ns/10ps
// ==========================================
// storage array, one write port, one read port
module dcf_ram #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8192,
    parameter int AW = 13
) (
    input wire logic sys_clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // write port
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read port presents the word at the read pointer
    assign rd_data = mem[rd_addr];
endmodule

//--- design/dcf_fifo.sv
`timescale 1ns/10ps
`include "dcf_consts.svh"
// ==========================================
// deep fifo with programmable flags
module dcf_fifo #(
    parameter int DEPTH = `DCF_DEPTH, // 8192 or 16384
    parameter int WIDTH = `DCF_WIDTH
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic write_clock,
    input wire logic write_enable_n,
    input wire logic [WIDTH-1:0] data_in_bus,
    input wire logic read_clock,
    input wire logic read_enable_n,
    input wire logic output_enable_n,
    input wire logic master_reset_n,
    input wire logic partial_reset_n,
    input wire logic retransmit_n,
    input wire logic fall_through_select,
    input wire logic serial_enable_n,
    input wire logic load_select_n,
    output logic [WIDTH-1:0] data_out_bus,
    output logic data_out_oe_n,
    output logic empty_flag_out_valid_n,
    output logic full_flag_space_free_n,
    output logic half_full_flag_n,
    output logic almost_empty_flag_n,
    output logic almost_full_flag_n
);
    localparam int AW = $clog2(DEPTH);
    localparam int PW = $bits(dcf_pkg::dcf_pins_t);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW:0] HALF_CNT = (AW+1)'(DEPTH / 2);
    localparam logic [1:0] FT_LAST = 2'(`DCF_FT_LATENCY - 1);

    // ==========================================
    // state
    typedef struct packed {
        dcf_pkg::dcf_pins_t pin_prev;
        dcf_pkg::dcf_mode_t mode;
        logic serial_meth;
        logic [AW:0] wptr;
        logic [AW:0] rptr;
        logic [AW-1:0] ae_off;
        logic [AW-1:0] af_off;
        logic wr_sel;
        logic rd_sel;
        logic out_valid;
        logic [1:0] ft_lat;
        logic rt_blank;
        logic [WIDTH-1:0] dout;
        logic ef_n;
        logic ff_n;
        logic hf_n;
        logic ae_n;
        logic af_n;
        logic oe_n;
    } dcf_state_t;

    dcf_state_t s;
    dcf_state_t next_s;
    dcf_pkg::dcf_pins_t pin;
    logic [PW-1:0] pin_raw;
    logic [PW-1:0] pin_sync;
    logic [WIDTH-1:0] mem_rd;
    logic mem_we;
    logic wr_edge;
    logic rd_edge;
    logic rd_tog;
    logic [AW:0] count;
    logic [AW:0] total;
    logic empty;
    logic full;
    logic fall;

    // ==========================================
    // pin sampling: clocks arrive as plain inputs
    assign pin_raw = {write_clock, read_clock, write_enable_n,
        read_enable_n, serial_enable_n, load_select_n, master_reset_n,
        partial_reset_n, retransmit_n, output_enable_n,
        fall_through_select, data_in_bus};

    dcf_sync #(
        .W(PW)
    ) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .async_in(pin_raw),
        .sync_out(pin_sync)
    );

    assign pin = dcf_pkg::dcf_pins_t'(pin_sync);

    // ==========================================
    // storage
    dcf_ram #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_ram (
        .sys_clk(sys_clk),
        .wr_en(mem_we),
        .wr_addr(s.wptr[AW-1:0]),
        .wr_data(s.pin_prev.din),
        .rd_addr(s.rptr[AW-1:0]),
        .rd_data(mem_rd)
    );

    // ==========================================
    // edges and occupancy
    // each clock is seen independently, no rate relation
    assign wr_edge = pin.wclk & ~s.pin_prev.wclk;
    assign rd_edge = pin.rclk & ~s.pin_prev.rclk;
    assign rd_tog = pin.rclk ^ s.pin_prev.rclk;
    assign fall = (s.mode == dcf_pkg::DCF_FALL);
    assign count = s.wptr - s.rptr;
    assign empty = (count == '0);
    assign full = (count == FULL_CNT);
    // in fall-through mode a word parked on the outputs still counts as held
    assign total = count + {{AW{1'b0}}, fall & s.out_valid};

    // ==========================================
    // next-state logic; controls come from the sample before the edge
    always_comb begin
        next_s = s;
        mem_we = 1'b0;
        next_s.pin_prev = pin;
        next_s.oe_n = pin.oe_n;
        if (!pin.mrs_n) begin
            // latch mode and load method, zero pointers
            next_s.mode = pin.fts ? dcf_pkg::DCF_FALL : dcf_pkg::DCF_HELD;
            next_s.serial_meth = ~pin.ld_n;
            if (pin.ld_n) begin
                next_s.ae_off = AW'(`DCF_OFF_PARALLEL);
                next_s.af_off = AW'(`DCF_OFF_PARALLEL);
            end else begin
                next_s.ae_off = AW'(`DCF_OFF_SERIAL);
                next_s.af_off = AW'(`DCF_OFF_SERIAL);
            end
            next_s.wptr = '0;
            next_s.rptr = '0;
            next_s.dout = '0;
            next_s.out_valid = 1'b0;
            next_s.ft_lat = '0;
            next_s.rt_blank = 1'b0;
            next_s.wr_sel = 1'b0;
            next_s.rd_sel = 1'b0;
        end else if (!pin.prs_n) begin
            // pointers, output word and load/readback order cleared, settings kept
            next_s.wptr = '0;
            next_s.rptr = '0;
            next_s.dout = '0;
            next_s.out_valid = 1'b0;
            next_s.ft_lat = '0;
            next_s.rt_blank = 1'b0;
            next_s.wr_sel = 1'b0;
            next_s.rd_sel = 1'b0;
        end else begin
            // write side: offset programming or data store
            if (wr_edge) begin
                if (!s.pin_prev.ld_n) begin
                    if (!s.pin_prev.sen_n && s.serial_meth) begin
                        // one bit per edge, low offset first
                        {next_s.af_off, next_s.ae_off} = {s.pin_prev.fts,
                            s.af_off, s.ae_off[AW-1:1]};
                    end else if (!s.pin_prev.wen_n && !s.serial_meth) begin
                        // almost-empty then almost-full
                        if (s.wr_sel) begin
                            next_s.af_off = s.pin_prev.din[AW-1:0];
                        end else begin
                            next_s.ae_off = s.pin_prev.din[AW-1:0];
                        end
                        next_s.wr_sel = ~s.wr_sel;
                    end
                end else if (!s.pin_prev.wen_n && !full) begin
                    // store the word, refused while full
                    mem_we = 1'b1;
                    next_s.wptr = s.wptr + 1'b1;
                end
            end
            // read side
            if (rd_edge && s.pin_prev.rt_n) begin
                next_s.rt_blank = 1'b0;
            end
            if (rd_edge && !s.pin_prev.rt_n) begin
                // reread from first location, write side untouched
                next_s.rptr = '0;
                next_s.out_valid = 1'b0;
                next_s.ft_lat = '0;
                next_s.rt_blank = 1'b1;
            end else if (rd_edge && !s.pin_prev.ren_n && !s.pin_prev.ld_n) begin
                // offset readback in either method
                next_s.dout = WIDTH'(s.rd_sel ? s.af_off : s.ae_off);
                next_s.rd_sel = ~s.rd_sel;
            end else if (!fall) begin
                // held mode: only an explicit read moves data
                if (rd_edge && !s.pin_prev.ren_n && !empty) begin
                    next_s.dout = mem_rd;
                    next_s.rptr = s.rptr + 1'b1;
                end
            end else if (s.out_valid) begin
                // later words need read enable
                if (rd_edge && !s.pin_prev.ren_n) begin
                    if (!empty) begin
                        next_s.dout = mem_rd;
                        next_s.rptr = s.rptr + 1'b1;
                    end else begin
                        next_s.out_valid = 1'b0;
                    end
                end
            end else if (!empty) begin
                // first word falls through on third transition
                if (rd_tog) begin
                    if (s.ft_lat == FT_LAST) begin
                        next_s.dout = mem_rd;
                        next_s.rptr = s.rptr + 1'b1;
                        next_s.out_valid = 1'b1;
                        next_s.ft_lat = '0;
                    end else begin
                        next_s.ft_lat = s.ft_lat + 1'b1;
                    end
                end
            end else begin
                next_s.ft_lat = '0;
            end
        end
        // flags, pin meaning depends on mode
        if (fall) begin
            next_s.ef_n = ~s.out_valid | s.rt_blank;
            next_s.ff_n = full;
        end else begin
            next_s.ef_n = ~empty & ~s.rt_blank;
            next_s.ff_n = ~full;
        end
        next_s.hf_n = ~(total > HALF_CNT);
        next_s.ae_n = ~(total <= {1'b0, s.ae_off});
        next_s.af_n = ~(total >= FULL_CNT - {1'b0, s.af_off});
    end

    // state register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.mode <= dcf_pkg::DCF_HELD;
            s.ef_n <= 1'b0;
            s.ff_n <= 1'b1;
            s.hf_n <= 1'b1;
            s.ae_n <= 1'b0;
            s.af_n <= 1'b1;
            s.oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================
    // outputs; fall-through data and ready chain into a next stage
    assign data_out_bus = s.dout;
    assign data_out_oe_n = s.oe_n;
    assign empty_flag_out_valid_n = s.ef_n;
    assign full_flag_space_free_n = s.ff_n;
    assign half_full_flag_n = s.hf_n;
    assign almost_empty_flag_n = s.ae_n;
    assign almost_full_flag_n = s.af_n;

    // ==========================================
    // assertions
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    mrs_clear_a: assert property (!pin.mrs_n |=>
        s.wptr == '0 && s.rptr == '0 && s.dout == '0)
        else $error("master reset did not clear pointers");
    prs_keep_a: assert property (pin.mrs_n && !pin.prs_n |=>
        $stable(s.mode) && $stable(s.ae_off) && $stable(s.af_off)
        && s.wptr == '0)
        else $error("partial reset lost settings");
    no_overrun_a: assert property (full && pin.mrs_n && pin.prs_n
        |=> s.wptr == $past(s.wptr))
        else $error("write pointer moved while full");
    held_empty_a: assert property (!fall && empty && pin.mrs_n
        && pin.prs_n && s.pin_prev.rt_n |=> s.rptr == $past(s.rptr))
        else $error("read pointer moved while empty");
    wr_store_a: assert property (pin.mrs_n && pin.prs_n && wr_edge
        && s.pin_prev.ld_n && !s.pin_prev.wen_n && !full
        |=> s.wptr == $past(s.wptr) + 1'b1)
        else $error("write not stored");
    rt_ptr_a: assert property (pin.mrs_n && pin.prs_n && rd_edge
        && !s.pin_prev.rt_n |=> s.rptr == '0 && s.rt_blank
        && s.wptr == $past(s.wptr) + $past(mem_we))
        else $error("retransmit did not rewind read side");
    ft_first_a: assert property (fall && !s.out_valid && !empty
        && s.ft_lat == FT_LAST && rd_tog && pin.mrs_n && pin.prs_n
        && s.pin_prev.rt_n |=> s.out_valid ##1 !s.ef_n)
        else $error("fall-through word not presented");
    hf_flag_a: assert property (total > HALF_CNT && pin.mrs_n
        && pin.prs_n ##1 $stable(total) |=> !s.hf_n)
        else $error("half-full flag not set");
    ser_load_a: assert property (pin.mrs_n && pin.prs_n && wr_edge
        && !s.pin_prev.ld_n && !s.pin_prev.sen_n && s.serial_meth
        |=> s.af_off[AW-1] == $past(s.pin_prev.fts))
        else $error("serial bit not shifted in");

    // flag levels, output drive and the remaining data paths
    ae_flag_a: assert property (total <= {1'b0, s.ae_off}
        |=> !s.ae_n)
        else $error("almost-empty flag not set");
    af_flag_a: assert property (total >= FULL_CNT
        - {1'b0, s.af_off} |=> !s.af_n)
        else $error("almost-full flag not set");
    held_full_a: assert property (!fall && full |=> !s.ff_n)
        else $error("full flag not set");
    ft_ready_a: assert property (fall && !full |=> !s.ff_n)
        else $error("input ready not shown");
    mode_latch_a: assert property (!pin.mrs_n
        |=> fall == $past(pin.fts))
        else $error("timing mode not latched");
    prs_out_a: assert property (pin.mrs_n && !pin.prs_n
        |=> s.dout == '0 && s.rptr == '0)
        else $error("partial reset did not clear output");
    oe_follow_a: assert property (1'b1
        |=> data_out_oe_n == $past(pin.oe_n))
        else $error("output enable not followed");
    held_read_a: assert property (!fall && rd_edge && pin.mrs_n
        && pin.prs_n && s.pin_prev.rt_n && s.pin_prev.ld_n
        && !s.pin_prev.ren_n && !empty
        |=> s.rptr == $past(s.rptr) + 1'b1 && s.dout == $past(mem_rd))
        else $error("held read did not advance");
    ft_hold_a: assert property (fall && s.out_valid && pin.mrs_n
        && pin.prs_n && !(rd_edge && (!s.pin_prev.ren_n
        || !s.pin_prev.rt_n)) |=> $stable(s.dout))
        else $error("parked word changed without a read");
    par_load_a: assert property (pin.mrs_n && pin.prs_n && wr_edge
        && !s.pin_prev.ld_n && !s.pin_prev.wen_n && !s.serial_meth
        |=> s.ae_off == $past(s.pin_prev.din[AW-1:0])
        || s.af_off == $past(s.pin_prev.din[AW-1:0]))
        else $error("parallel offset not captured");

    ft_word_c: cover property (fall && !s.out_valid ##1 s.out_valid);
    rt_c: cover property (s.rt_blank ##[1:50] !s.rt_blank);
    full_c: cover property (full);
    readback_c: cover property (rd_edge && !s.pin_prev.ld_n
        && !s.pin_prev.ren_n);
    ser_load_c: cover property (wr_edge && !s.pin_prev.ld_n
        && !s.pin_prev.sen_n && s.serial_meth);
endmodule

//--- verif/dcf_far_end.sv
`timescale 1ns/10ps
`include "dcf_consts.svh"
// ==========================================
// producer and consumer pin driver facing the fifo
module dcf_far_end (
    input wire logic sys_clk,
    output logic write_clock,
    output logic write_enable_n,
    output logic [`DCF_WIDTH-1:0] data_in_bus,
    output logic serial_enable_n,
    output logic read_clock,
    output logic read_enable_n,
    output logic retransmit_n
);
    // sys_clk cycles per pin clock phase, above the two-cycle minimum
    localparam int PH = 4;

    // ==========================================
    // idle levels; clocks stand still between cycles
    initial begin
        write_clock = 1'b0;
        write_enable_n = 1'b1;
        data_in_bus = '0;
        serial_enable_n = 1'b1;
        read_clock = 1'b0;
        read_enable_n = 1'b1;
        retransmit_n = 1'b1;
    end

    // one write clock cycle, word and enable held around the rise
    task automatic wcycle(input logic wen_n, input logic [`DCF_WIDTH-1:0] d);
        @(posedge sys_clk);
        write_enable_n <= wen_n;
        data_in_bus <= d;
        repeat (PH) @(posedge sys_clk);
        write_clock <= 1'b1;
        repeat (PH) @(posedge sys_clk);
        write_clock <= 1'b0;
        repeat (PH) @(posedge sys_clk);
        write_enable_n <= 1'b1;
        data_in_bus <= ~d; // released bus never shows the old word
    endtask

    // one serial offset bit, enable held around the write clock rise
    task automatic scycle();
        @(posedge sys_clk);
        serial_enable_n <= 1'b0;
        repeat (PH) @(posedge sys_clk);
        write_clock <= 1'b1;
        repeat (PH) @(posedge sys_clk);
        write_clock <= 1'b0;
        repeat (PH) @(posedge sys_clk);
        serial_enable_n <= 1'b1;
    endtask

    // one read clock cycle: two transitions, enable held around the rise
    task automatic rcycle(input logic ren_n, input logic rt_n);
        @(posedge sys_clk);
        read_enable_n <= ren_n;
        retransmit_n <= rt_n;
        repeat (PH) @(posedge sys_clk);
        read_clock <= 1'b1;
        repeat (PH) @(posedge sys_clk);
        read_clock <= 1'b0;
        repeat (PH) @(posedge sys_clk);
        read_enable_n <= 1'b1;
        retransmit_n <= 1'b1;
    endtask
endmodule

//--- verif/dcf_fifo_bench.sv
`timescale 1ns/10ps
`include "dcf_consts.svh"
// ==========================================
// self-checking bench for the dual clock fifo
module dcf_fifo_bench;
    localparam int DEPTH = 16;
    localparam int AW = 4;
    logic sys_clk, resetn, output_enable_n, master_reset_n, partial_reset_n;
    logic fall_through_select, load_select_n, write_clock, write_enable_n;
    logic serial_enable_n, read_clock, read_enable_n, retransmit_n;
    logic [`DCF_WIDTH-1:0] data_in_bus, data_out_bus, last, w1, w2;
    logic data_out_oe_n, ef_n, ff_n, hf_n, ae_n, af_n;
    logic [`DCF_WIDTH-1:0] words[$];
    logic [`DCF_WIDTH-1:0] sent[$];
    logic [AW-1:0] ae_off, af_off;
    logic [2*AW-1:0] sval;
    int n_fail, compares, cycles, occ;

    dcf_fifo #(.DEPTH(DEPTH)) dut_u (
        .sys_clk(sys_clk), .resetn(resetn), .write_clock(write_clock),
        .write_enable_n(write_enable_n), .data_in_bus(data_in_bus),
        .read_clock(read_clock), .read_enable_n(read_enable_n),
        .output_enable_n(output_enable_n), .master_reset_n(master_reset_n),
        .partial_reset_n(partial_reset_n), .retransmit_n(retransmit_n),
        .fall_through_select(fall_through_select),
        .serial_enable_n(serial_enable_n), .load_select_n(load_select_n),
        .data_out_bus(data_out_bus), .data_out_oe_n(data_out_oe_n),
        .empty_flag_out_valid_n(ef_n), .full_flag_space_free_n(ff_n),
        .half_full_flag_n(hf_n), .almost_empty_flag_n(ae_n),
        .almost_full_flag_n(af_n)
    );

    dcf_far_end far_u (
        .sys_clk(sys_clk), .write_clock(write_clock),
        .write_enable_n(write_enable_n), .data_in_bus(data_in_bus),
        .serial_enable_n(serial_enable_n), .read_clock(read_clock),
        .read_enable_n(read_enable_n), .retransmit_n(retransmit_n)
    );

    // ==========================================
    // 200 MHz clock and hang limit
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            end_sim();
        end
    end

    // ==========================================
    // comparisons, expectations and the verdict
    task automatic chk_data(input logic [`DCF_WIDTH-1:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flags(input logic [4:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: flags %b expected %b", $time, got, exp);
        end
    endtask

    function automatic logic [4:0] flags();
        return {ef_n, ff_n, hf_n, ae_n, af_n};
    endfunction

    // held-mode flag levels for an occupancy, all active low
    function automatic logic [4:0] exp_flags(input int n);
        return {n != 0, n != DEPTH, !(n > DEPTH / 2), !(n <= ae_off),
            !(n >= DEPTH - af_off)};
    endfunction

    task automatic end_sim();
        if (n_fail == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // reset and traffic helpers that keep the reference queue
    task automatic clear_model();
        words = {};
        sent = {};
        occ = 0;
        last = '0;
    endtask

    task automatic mreset(input logic fts, input logic ld_n);
        fall_through_select <= fts;
        load_select_n <= ld_n;
        master_reset_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        master_reset_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        load_select_n <= 1'b1;
        ae_off = ld_n ? AW'(`DCF_OFF_PARALLEL) : AW'(`DCF_OFF_SERIAL);
        af_off = ae_off;
        clear_model();
    endtask

    task automatic preset();
        partial_reset_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        partial_reset_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        clear_model();
        chk_data(data_out_bus, '0);
        chk_flags(flags(), exp_flags(0));
    endtask

    task automatic put(input int n);
        logic [`DCF_WIDTH-1:0] w;
        repeat (n) begin
            w = `DCF_WIDTH'($urandom);
            far_u.wcycle(1'b0, w);
            if (occ < DEPTH) begin
                words.push_back(w);
                sent.push_back(w);
                occ++;
            end
            chk_flags(flags(), exp_flags(occ));
        end
    endtask

    task automatic get(input int n);
        repeat (n) begin
            far_u.rcycle(1'b0, 1'b1);
            if (occ > 0) begin
                last = words.pop_front();
                occ--;
            end
            chk_data(data_out_bus, last);
            chk_flags(flags(), exp_flags(occ));
        end
    endtask

    task automatic readback();
        load_select_n <= 1'b0;
        far_u.rcycle(1'b0, 1'b1);
        chk_data(`DCF_WIDTH'(data_out_bus[AW-1:0]), `DCF_WIDTH'(ae_off));
        far_u.rcycle(1'b0, 1'b1);
        chk_data(`DCF_WIDTH'(data_out_bus[AW-1:0]), `DCF_WIDTH'(af_off));
        load_select_n <= 1'b1;
    endtask

    // ==========================================
    // main sequence
    initial begin
        resetn = 1'b0;
        output_enable_n = 1'b0;
        master_reset_n = 1'b1;
        partial_reset_n = 1'b1;
        fall_through_select = 1'b0;
        load_select_n = 1'b1;
        n_fail = 0;
        compares = 0;
        cycles = 0;
        void'($urandom(32'h7b2f2db6));
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        mreset(1'b0, 1'b1);
        chk_data(data_out_bus, '0);
        chk_flags(flags(), exp_flags(0));
        put(1);
        chk_data(data_out_bus, '0);
        put(DEPTH);
        get(DEPTH + 1);
        preset();
        put(10);
        get(4);
        far_u.rcycle(1'b1, 1'b0);
        chk_flags({ef_n, 4'h0}, 5'h00);
        words = sent;
        occ = sent.size();
        far_u.rcycle(1'b1, 1'b1);
        chk_flags(flags(), exp_flags(occ));
        get(occ);
        // parallel offset load, flags follow the new thresholds
        mreset(1'b0, 1'b1);
        load_select_n <= 1'b0;
        ae_off = AW'($urandom_range(6, 1));
        af_off = AW'($urandom_range(6, 1));
        far_u.wcycle(1'b0, `DCF_WIDTH'(ae_off));
        far_u.wcycle(1'b0, `DCF_WIDTH'(af_off));
        load_select_n <= 1'b1;
        readback();
        put(DEPTH);
        get(3);
        preset();
        readback();
        // serial offset load, one bit per write clock rise, low bit first
        mreset(1'b0, 1'b0);
        chk_flags(flags(), exp_flags(0));
        sval = (2*AW)'($urandom);
        load_select_n <= 1'b0;
        for (int i = 0; i < 2 * AW; i++) begin
            fall_through_select <= sval[i];
            far_u.scycle();
        end
        load_select_n <= 1'b1;
        fall_through_select <= 1'b0;
        {af_off, ae_off} = sval;
        readback();
        put(DEPTH);
        get(DEPTH);
        // fall-through mode: first word without enable, later with
        mreset(1'b1, 1'b1);
        chk_flags({ef_n, ff_n, 3'h0}, 5'b10000);
        w1 = `DCF_WIDTH'($urandom);
        w2 = `DCF_WIDTH'($urandom);
        far_u.wcycle(1'b0, w1);
        far_u.rcycle(1'b1, 1'b1);
        chk_data(data_out_bus, '0);
        far_u.rcycle(1'b1, 1'b1);
        chk_data(data_out_bus, w1);
        chk_flags({ef_n, 4'h0}, 5'h00);
        far_u.wcycle(1'b0, w2);
        far_u.rcycle(1'b1, 1'b1);
        chk_data(data_out_bus, w1);
        far_u.rcycle(1'b0, 1'b1);
        chk_data(data_out_bus, w2);
        far_u.rcycle(1'b0, 1'b1);
        chk_flags({ef_n, 4'h0}, 5'h10);
        // output drive checked on, then switched off
        chk_flags({data_out_oe_n, 4'h0}, 5'h00);
        output_enable_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk_flags({data_out_oe_n, 4'h0}, 5'h10);
        end_sim();
    end
endmodule
